// [pkg/mmc_regs.vh]
`ifndef MMC_REGS_VH
`define MMC_REGS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define MMC_CLK_MHZ      20
`define MMC_RST_MIN_NS   10000
`define MMC_INIT_US      2000
`define MMC_RST_MIN_CYC  ((`MMC_RST_MIN_NS * `MMC_CLK_MHZ + 999) / 1000)
`define MMC_INIT_CYC     (`MMC_INIT_US * `MMC_CLK_MHZ)

// ****************************************************************
// Two-wire bus address and management byte map
// ****************************************************************
`define MMC_DEV_ADDR     7'h50
`define MMC_OFS_STATUS   8'h00
`define MMC_OFS_CTRL     8'h01
`define MMC_ST_RSTDONE   0
`define MMC_ST_FAULT     1
`define MMC_CT_LP        0
`define MMC_CTRL_RST     8'h00

`endif

// [rtl/mmc_sync.v]
// ****************************************************************
// Two-flop synchroniser, resets to the idle (high) level
// ****************************************************************
module mmc_sync #(
	parameter W = 1
) (
	// Clock and control
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire         i_ce,
	// Data
	input  wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end else if (i_ce) begin
			meta_ff <= i_d;
			sync_ff <= meta_ff;
		end
	end

	assign o_q = sync_ff;
endmodule

// [rtl/mmc_ctrl.v]
`include "mmc_regs.vh"

// Notes on behaviour
// - Serve two-wire bus only while selected low
// - Deselected: ignore bus, never ack or drive
// - Select input reads high only until first sampled after reset
// - Long reset-pin low restores default state
// - Reset-complete flag raised after power-up init
// - Low-power indication is active high
// - Open-drain interrupt pulled low on fault
// - Presence pin tied low inside module
// - Controller serves control and status bytes
module mmc_ctrl #(
	parameter RST_MIN_CYC = `MMC_RST_MIN_CYC,
	parameter INIT_CYC    = `MMC_INIT_CYC
) (
	// Clock, reset, enable
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_ce,
	// Host control pins
	input  wire i_module_select_n,
	input  wire i_module_reset_n,
	// Two-wire bus
	input  wire i_scl,
	input  wire i_sda_in,
	output reg  o_sda_out,
	output reg  o_sda_oe,
	// Internal fault source
	input  wire i_fault,
	// Module status pins
	output reg  o_fault_irq_n_out,
	output reg  o_fault_irq_n_oe,
	output reg  o_low_power_ind,
	output reg  o_presence_n
);
	// ************************************************************
	// States
	// ************************************************************
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_ACK_A = 3'h2;
	localparam [2:0] ST_WR    = 3'h3;
	localparam [2:0] ST_ACK_W = 3'h4;
	localparam [2:0] ST_RD    = 3'h5;
	localparam [2:0] ST_ACK_R = 3'h6;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	wire sel_n_s;
	wire rstp_n_s;
	wire scl_s;
	wire sda_s;

	// Reset value high keeps select deselected until the pin is sampled
	mmc_sync #(.W(4)) u_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   ({i_module_select_n, i_module_reset_n, i_scl, i_sda_in}),
		.o_q   ({sel_n_s, rstp_n_s, scl_s, sda_s})
	);

	// ************************************************************
	// Reset pin filter and initialisation timer
	// ************************************************************
	reg  [15:0] rlow_cnt_ff;
	reg         mod_rst_ff;
	reg  [15:0] init_cnt_ff;
	reg         init_busy_ff;
	wire        init_done;
	always @(posedge i_clk) begin
		if (i_rst) begin
			rlow_cnt_ff <= 16'h0000;
			mod_rst_ff  <= 1'b0;
		end else if (i_ce) begin
			if (rstp_n_s) begin
				rlow_cnt_ff <= 16'h0000;
				mod_rst_ff  <= 1'b0;
			end else if (rlow_cnt_ff == RST_MIN_CYC[15:0] - 16'h0001) begin
				mod_rst_ff  <= 1'b1;
			end else begin
				rlow_cnt_ff <= rlow_cnt_ff + 16'h0001;
			end
		end
	end
	// Runs after power-up too, so hot insertion also reports done
	always @(posedge i_clk) begin
		if (i_rst) begin
			init_cnt_ff  <= 16'h0000;
			init_busy_ff <= 1'b1;
		end else if (i_ce) begin
			if (mod_rst_ff) begin
				init_cnt_ff  <= 16'h0000;
				init_busy_ff <= 1'b1;
			end else if (init_busy_ff) begin
				if (init_cnt_ff == INIT_CYC[15:0] - 16'h0001)
					init_busy_ff <= 1'b0;
				else
					init_cnt_ff <= init_cnt_ff + 16'h0001;
			end
		end
	end
	assign init_done = init_busy_ff && !mod_rst_ff &&
		(init_cnt_ff == INIT_CYC[15:0] - 16'h0001);

	// ************************************************************
	// Bus edge detection
	// ************************************************************
	reg  scl_d_ff;
	reg  sda_d_ff;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	always @(posedge i_clk) begin
		if (i_rst) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else if (i_ce) begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end
	assign scl_rise  = scl_s && !scl_d_ff;
	assign scl_fall  = !scl_s && scl_d_ff;
	assign bus_start = scl_s && scl_d_ff && !sda_s && sda_d_ff;
	assign bus_stop  = scl_s && scl_d_ff && sda_s && !sda_d_ff;

	// ************************************************************
	// Two-wire slave engine
	// ************************************************************
	reg  [2:0] st_ff;
	reg  [3:0] bit_cnt_ff;
	reg  [7:0] sh_ff;
	reg  [7:0] ptr_ff;
	reg        rw_ff;
	reg        first_ff;
	reg        mack_ff;
	reg        lp_ff;
	reg        st_fault_ff;
	reg        st_done_ff;
	reg  [7:0] rd_byte;
	reg        rd_clr;
	reg        lp_wr;
	reg        lp_val;
	localparam [7:0] CTRL_RST = `MMC_CTRL_RST;
	always @* begin
		rd_byte = 8'h00;
		case (ptr_ff)
		`MMC_OFS_STATUS: begin
			rd_byte[`MMC_ST_RSTDONE] = st_done_ff;
			rd_byte[`MMC_ST_FAULT]   = st_fault_ff;
		end
		`MMC_OFS_CTRL: rd_byte[`MMC_CT_LP] = lp_ff;
		default: rd_byte = 8'h00;
		endcase
	end
	// Strobes move only with the enable, so a pulse survives a stall
	always @(posedge i_clk) begin
		if (i_rst || mod_rst_ff) begin
			rd_clr     <= 1'b0;
			lp_wr      <= 1'b0;
			st_ff      <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			sh_ff      <= 8'h00;
			ptr_ff     <= 8'h00;
			rw_ff      <= 1'b0;
			first_ff   <= 1'b0;
			mack_ff    <= 1'b0;
			o_sda_out  <= 1'b0;
			o_sda_oe   <= 1'b0;
		end else if (i_ce) begin
			rd_clr <= 1'b0;
			lp_wr  <= 1'b0;
			if (sel_n_s || init_busy_ff) begin
				st_ff    <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else if (bus_start) begin
				st_ff      <= ST_ADDR;
				bit_cnt_ff <= 4'h0;
				o_sda_oe   <= 1'b0;
			end else if (bus_stop) begin
				st_ff    <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				case (st_ff)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						sh_ff      <= {sh_ff[6:0], sda_s};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall && bit_cnt_ff == 4'h8) begin
						bit_cnt_ff <= 4'h0;
						if (st_ff == ST_ADDR) begin
							if (sh_ff[7:1] == `MMC_DEV_ADDR) begin
								rw_ff    <= sh_ff[0];
								o_sda_oe <= 1'b1;
								st_ff    <= ST_ACK_A;
							end else begin
								st_ff <= ST_IDLE;
							end
						end else begin
							o_sda_oe <= 1'b1;
							st_ff    <= ST_ACK_W;
							first_ff <= 1'b0;
							if (first_ff) begin
								ptr_ff <= sh_ff;
							end else begin
								ptr_ff <= ptr_ff + 8'h01;
								if (ptr_ff == `MMC_OFS_CTRL) begin
									lp_wr  <= 1'b1;
									lp_val <= sh_ff[`MMC_CT_LP];
								end
							end
						end
					end
				end
				ST_ACK_A, ST_ACK_R: begin
					if (scl_rise)
						mack_ff <= !sda_s;
					if (scl_fall) begin
						bit_cnt_ff <= 4'h0;
						if (st_ff == ST_ACK_A && !rw_ff) begin
							o_sda_oe <= 1'b0;
							first_ff <= 1'b1;
							st_ff    <= ST_WR;
						end else if (st_ff == ST_ACK_A || mack_ff) begin
							sh_ff    <= rd_byte;
							o_sda_oe <= !rd_byte[7];
							ptr_ff   <= ptr_ff + 8'h01;
							rd_clr   <= (ptr_ff == `MMC_OFS_STATUS);
							st_ff    <= ST_RD;
						end else begin
							o_sda_oe <= 1'b0;
							st_ff    <= ST_IDLE;
						end
					end
				end
				ST_ACK_W: begin
					if (scl_fall) begin
						o_sda_oe <= 1'b0;
						st_ff    <= ST_WR;
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_ff == 4'h8) begin
							o_sda_oe <= 1'b0;
							st_ff    <= ST_ACK_R;
						end else begin
							sh_ff    <= {sh_ff[6:0], 1'b0};
							o_sda_oe <= !sh_ff[6];
						end
					end
				end
				default: begin
					o_sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// ************************************************************
	// Status, control and pin outputs
	// ************************************************************
	always @(posedge i_clk) begin
		if (i_rst || mod_rst_ff) begin
			st_fault_ff <= 1'b0;
			st_done_ff  <= 1'b0;
			lp_ff       <= CTRL_RST[`MMC_CT_LP];
		end else if (i_ce) begin
			// A new event in the clearing cycle survives
			st_fault_ff <= i_fault || (st_fault_ff && !rd_clr);
			st_done_ff  <= init_done || (st_done_ff && !rd_clr);
			if (lp_wr)
				lp_ff <= lp_val;
		end
	end
	always @(posedge i_clk) begin
		o_fault_irq_n_out <= 1'b0;
		o_presence_n      <= 1'b0;
		if (i_rst) begin
			o_fault_irq_n_oe  <= 1'b0;
			o_low_power_ind   <= 1'b0;
		end else if (i_ce) begin
			o_fault_irq_n_oe  <= st_fault_ff || st_done_ff;
			o_low_power_ind   <= lp_ff;
		end
	end
endmodule

// [test/mmc_props.sv]
module mmc_props #(
	parameter RST_MIN_CYC = 4,
	parameter INIT_CYC    = 20
) (
	// Clock, reset and enable
	input logic i_clk,
	input logic i_rst,
	input logic i_ce,
	// Pins
	input logic i_module_select_n,
	input logic i_module_reset_n,
	input logic i_fault,
	input logic o_sda_out,
	input logic o_sda_oe,
	input logic o_fault_irq_n_out,
	input logic o_fault_irq_n_oe,
	input logic o_low_power_ind,
	input logic o_presence_n
);
	logic [15:0] rcnt_ff;
	logic [15:0] icnt_ff;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst || !i_ce);
	// Reset-pin low run length and cycles since power-up
	always @(posedge i_clk) begin
		rcnt_ff <= i_module_reset_n ? 16'h0 : rcnt_ff + 16'h1;
		if (i_rst)
			icnt_ff <= 16'h0;
		else if (icnt_ff != 16'hffff)
			icnt_ff <= icnt_ff + 16'h1;
	end
	a_presence_low: assert property (o_presence_n == 1'b0)
		else $error("presence pin not low");
	a_desel_quiet: assert property (
		i_module_select_n [*5] |-> !o_sda_oe)
		else $error("data line driven while deselected");
	a_sda_od: assert property (o_sda_oe |-> !o_sda_out)
		else $error("data line driven high");
	a_irq_od: assert property (
		o_fault_irq_n_oe |-> !o_fault_irq_n_out)
		else $error("interrupt pin driven high");
	a_fault_irq: assert property (
		i_fault |-> ##[1:4] o_fault_irq_n_oe)
		else $error("fault did not pull interrupt low");
	a_rst_long: assert property (
		rcnt_ff == RST_MIN_CYC + 3 |-> ##[0:6] !o_low_power_ind)
		else $error("long reset pulse kept low-power bit");
	a_rst_short: assert property (
		o_low_power_ind && i_module_reset_n ##1 !i_module_reset_n [*2]
		##1 i_module_reset_n [*6] |-> o_low_power_ind)
		else $error("short reset pulse not filtered");
	a_init_done: assert property (
		icnt_ff == INIT_CYC + 6 |-> o_fault_irq_n_oe)
		else $error("no reset-complete interrupt after init");
	c_ack: cover property ($rose(o_sda_oe));
	c_lp: cover property ($rose(o_low_power_ind));
	c_irq_clr: cover property ($fell(o_fault_irq_n_oe));
endmodule

bind mmc_ctrl mmc_props #(
	.RST_MIN_CYC(RST_MIN_CYC),
	.INIT_CYC(INIT_CYC)
) u_props (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_ce(i_ce),
	.i_module_select_n(i_module_select_n),
	.i_module_reset_n(i_module_reset_n),
	.i_fault(i_fault),
	.o_sda_out(o_sda_out),
	.o_sda_oe(o_sda_oe),
	.o_fault_irq_n_out(o_fault_irq_n_out),
	.o_fault_irq_n_oe(o_fault_irq_n_oe),
	.o_low_power_ind(o_low_power_ind),
	.o_presence_n(o_presence_n)
);

// [test/mmc_host.sv]
// ****************************************************************
// Two-wire bus host, 400 ns bus clock, idle high between frames
// ****************************************************************
module mmc_host (
	// Bus pins
	output logic o_scl,
	output logic o_sda_low,
	input  wire  i_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Also serves as repeated start; select is set by the bench
	task automatic start;
		o_sda_low = 1'b0;
		#100 o_scl = 1'b1;
		#100 o_sda_low = 1'b1;
		#100 o_scl = 1'b0;
		#100;
	endtask
	task automatic stop;
		o_sda_low = 1'b1;
		#100 o_scl = 1'b1;
		#100 o_sda_low = 1'b0;
		#200;
	endtask
	// Data changes only while the bus clock is low
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		#100 o_scl = 1'b1;
		#100 r = i_sda;
		#100 o_scl = 1'b0;
		#100;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// Reads one byte at the current pointer, ends with a no-ack
	task automatic rbyte(output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b = {b[6:0], r};
		end
		bit_io(1'b1, r);
	endtask
endmodule

// [test/test_mmc_ctrl.sv]
module test_mmc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic sel_n = 1'b1;
	logic rst_n = 1'b1;
	logic fault = 1'b0;
	logic ce = 1'b1;
	logic scl, h_low, sda_oe, sda_out, irq_out, irq_oe, lp, prs_n, a;
	logic [7:0] d;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	// Address rows: select, address byte, expected ack
	logic [9:0] rows [3] = '{10'h141, 10'h144, 10'h340};
	wire sda = !(h_low || (sda_oe && !sda_out));
	initial forever #25 i_clk = !i_clk;
	mmc_ctrl #(.RST_MIN_CYC(4), .INIT_CYC(20)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
		.i_module_select_n(sel_n), .i_module_reset_n(rst_n),
		.i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .i_fault(fault),
		.o_fault_irq_n_out(irq_out), .o_fault_irq_n_oe(irq_oe),
		.o_low_power_ind(lp), .o_presence_n(prs_n));
	mmc_host host (.o_scl(scl), .o_sda_low(h_low), .i_sda(sda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic rd_stat(input logic [7:0] p);
		host.start;
		host.wbyte(8'ha0, a);
		host.wbyte(p, a);
		host.start;
		host.wbyte(8'ha1, a);
		host.rbyte(d);
		host.stop;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		wait_clk(2);
		i_rst <= 1'b0;
		wait_clk(1);
		#1;
		chk(prs_n, 8'h0);
		chk(lp, 8'h0);
		wait_clk(30);
		chk(irq_oe, 8'h1);
		$display("test power-up done");
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk) sel_n <= rows[i][9];
			host.start;
			host.wbyte(rows[i][8:1], a);
			host.stop;
			chk(a, rows[i][0]);
			$display("test address row %0d done", i);
		end
		@(posedge i_clk) sel_n <= 1'b0;
		host.start;
		host.wbyte(8'ha0, a);
		host.wbyte(8'h01, a);
		host.wbyte(8'h01, a);
		host.stop;
		chk(lp, 8'h1);
		rd_stat(8'h01);
		chk(d, 8'h01);
		rd_stat(8'h00);
		chk(d, 8'h01);
		wait_clk(5);
		chk(irq_oe, 8'h0);
		@(posedge i_clk) fault <= 1'b1;
		@(posedge i_clk) fault <= 1'b0;
		wait_clk(4);
		chk(irq_oe, 8'h1);
		rd_stat(8'h00);
		chk(d, 8'h02);
		$display("test control and status done");
		@(posedge i_clk) rst_n <= 1'b0;
		wait_clk(2);
		rst_n <= 1'b1;
		wait_clk(10);
		chk(lp, 8'h1);
		rst_n <= 1'b0;
		wait_clk(8);
		rst_n <= 1'b1;
		wait_clk(4);
		chk(lp, 8'h0);
		wait_clk(30);
		chk(irq_oe, 8'h1);
		$display("test reset pin done");
		rd_stat(8'h00);
		chk(d, 8'h01);
		wait_clk(5);
		chk(irq_oe, 8'h0);
		@(posedge i_clk) ce <= 1'b0;
		fault <= 1'b1;
		@(posedge i_clk) fault <= 1'b0;
		wait_clk(4);
		chk(irq_oe, 8'h0);
		ce <= 1'b1;
		wait_clk(4);
		chk(irq_oe, 8'h0);
		$display("test clock enable done");
		print_verdict;
	end
endmodule
